//--- design/fcc_ctrl.sv
`timescale 1ns/1ps
// Contract
// (R1) enabling the cache starts a flush of every entry before any lookup
// (R2) ready status after flush; then serve instruction/data per enables
// (R3) instruction and data caching enables act independently, any time
// (R4) fetches inside an enabled non-cacheable region bypass the cache
// (R5) invalidate all on flash erase/program and on enable clear
// (R6) command register reads status only; writing ones triggers actions
// (R7) software disables, reconfigures, then re-enables the cache
// (R8) 8 KB, two-way, 512 entries, 128-bit lines; the store holds 512 x 128 bits = 8 KB
// (R9) hits answer with no wait state; misses request a flash fill
// (R10) one shared cache; fill path arbitrated with other flash readers
// (R11) no fetch served from flash while erase or program runs; a fill already sent to flash still completes and is served
// (R12) per-bus counts: reads, lookups, hits, line-served reads
// (R13) lookups plus line-served reads equal total reads per bus
// (R14) all counters freeze once a read total reaches 0xffff0000
// (R15) monitor-clear command zeroes all counters at any time
// (R16) software reads statistics only with monitoring off
// (R17) wait states on misses and lookup contention, not counted
// (R18) counting only while monitor enable bit 24 is set
// (R19) ready bit 2 set only when enabled and not invalidating
// (R20) command bit 0 written one starts full invalidation
// (R21) policy bit chooses least recently replaced or least recently used
// (R22) counters are 32 bits, one per qualifying event
module fcc_ctrl
  import fcc_pkg::*;
(
  input  wire logic                    clock_i,
  input  wire logic                    resetn_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [fcc_pkg::DW-1:0]  reg_wdata_i,
  input  wire logic                    reg_we_i,
  input  wire logic                    reg_re_i,
  output logic [fcc_pkg::DW-1:0]       reg_rdata_o,
  input  wire logic                    ibus_req_i,
  input  wire logic [fcc_pkg::AW-1:0]  ibus_addr_i,
  output logic                         ibus_ack_o,
  output logic [fcc_pkg::DW-1:0]       ibus_rdata_o,
  input  wire logic                    dbus_req_i,
  input  wire logic [fcc_pkg::AW-1:0]  dbus_addr_i,
  output logic                         dbus_ack_o,
  output logic [fcc_pkg::DW-1:0]       dbus_rdata_o,
  input  wire logic                    flash_busy_i,
  output logic                         fill_req_o,
  output logic [fcc_pkg::LNW-1:0]      fill_addr_o,
  input  wire logic                    fill_ack_i,
  input  wire logic [fcc_pkg::LW-1:0]  fill_data_i,
  input  wire logic [fcc_pkg::NAG-1:0] agent_req_i,
  output logic [fcc_pkg::NAG-1:0]      agent_gnt_o
);
  import fcc_pkg::*;

  fcc_state_t st_q;
  logic [DW-1:0]    cfg_q;
  logic [LNW-1:0]   ncr_q [4];
  logic [SW-1:0]    fcnt_q;
  logic             flush_pend_q, en_prev_q, busy_prev_q, ready_q, rr_q;
  logic             own_q, fbus_q, fwr_q, fway_q;
  logic [AW-1:0]    faddr_q;
  logic [1:0]       lb_v_q;
  logic [LNW-1:0]   lb_line_q [2];
  logic [LW-1:0]    lb_data_q [2];
  logic [1:0][NMON-1:0]         ev;
  logic [1:0][NMON-1:0][DW-1:0] mon_cnt;
  logic [1:0]       req, bus_en, pend, lbhit, need_lk, need_nc;
  logic [1:0]       hit_v, done_b;
  logic [AW-1:0]    addr [2];
  logic [AW-1:0]    la;
  logic             lk_go, lk_bus, lk_hit, hit_way, nc_go, nc_bus;
  logic             fill_go, fill_bus, fill_done, serve_ok, flush_ev;
  logic             inv_cmd, clr_cmd, path_free, cache_wants;
  logic [DW-1:0]    rd_d;

  fcc_store_if sif ();

  fcc_store u_store (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .s        (sif.store)
  );

  fcc_mon u_mon (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ev_i     (ev),
    .en_i     (cfg_q[CFG_MON]), // [R18]
    .clr_i    (clr_cmd),
    .cnt_o    (mon_cnt)
  );

  function automatic logic is_nc(logic [AW-1:0] a, logic [DW-1:0] c,
                                 logic [LNW-1:0] s0, logic [LNW-1:0] e0,
                                 logic [LNW-1:0] s1, logic [LNW-1:0] e1);
    logic [LNW-1:0] l;
    l = line_of(a);
    return (c[CFG_NC0] && l >= s0 && l <= e0) ||
           (c[CFG_NC1] && l >= s1 && l <= e1);
  endfunction : is_nc

  assign req     = {dbus_req_i, ibus_req_i};
  assign addr[0] = ibus_addr_i;
  assign addr[1] = dbus_addr_i;
  assign bus_en  = {cfg_q[CFG_DC], cfg_q[CFG_IC]}; // [R3]
  assign inv_cmd = reg_we_i && reg_addr_i == CMD_OFS &&
                   reg_wdata_i[CMD_INV]; // [R20]
  assign clr_cmd = reg_we_i && reg_addr_i == CMD_OFS &&
                   reg_wdata_i[CMD_CLR]; // [R15]
  assign flush_ev = inv_cmd || (cfg_q[CFG_EN] != en_prev_q) ||
                    (flash_busy_i && !busy_prev_q); // [R1] [R5]
  // erase/program stalls every fetch except a fill already sent to flash; flash contents are in flux
  assign serve_ok = st_q == FCC_IDLE && !flash_busy_i &&
                    !flush_pend_q; // [R11]
  assign fill_done = st_q == FCC_FILL && own_q && fill_ack_i;
  assign path_free = !own_q && agent_gnt_o == '0;
  assign cache_wants = st_q == FCC_FILL && !flash_busy_i;

  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      pend[b]  = req[b] && !done_b[b] && serve_ok;
      lbhit[b] = pend[b] && lb_v_q[b] &&
                 lb_line_q[b] == line_of(addr[b]);
      need_lk[b] = pend[b] && !lbhit[b] && ready_q && bus_en[b] &&
                   !is_nc(addr[b], cfg_q, ncr_q[0], ncr_q[1],
                          ncr_q[2], ncr_q[3]); // [R2] [R4]
      need_nc[b] = pend[b] && !lbhit[b] && !need_lk[b];
    end
    // single tag port: the losing bus waits a cycle after a winner hit, or until the winner's fill ends
    lk_go  = |need_lk;
    lk_bus = &need_lk ? rr_q : need_lk[1]; // [R17]
    la     = addr[lk_bus];
    sif.rd_set = set_of(la);
    for (int w = 0; w < 2; w++)
      hit_v[w] = sif.rd_vld[w] && sif.rd_tag[w] == tag_of(la);
    lk_hit  = lk_go && |hit_v;
    hit_way = hit_v[1];
    nc_go   = !lk_go && |need_nc;
    nc_bus  = !need_nc[0];
    fill_go = (lk_go && !lk_hit) || nc_go; // [R9]
    fill_bus = lk_go ? lk_bus : nc_bus;
    for (int b = 0; b < 2; b++)
    begin
      ev[b][MON_LK]  = lk_go && lk_bus == b; // [R12]
      ev[b][MON_HIT] = lk_hit && lk_bus == b;
      ev[b][MON_LN]  = lbhit[b] || (nc_go && nc_bus == b);
      ev[b][MON_ACC] = ev[b][MON_LK] || ev[b][MON_LN]; // [R13]
    end
  end

  assign done_b = {dbus_ack_o, ibus_ack_o};

  // register write side
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_q <= CFG_RST;
      for (int i = 0; i < 4; i++)
        ncr_q[i] <= '0;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i == CFG_OFS)
        cfg_q <= reg_wdata_i & CFG_WMASK;
      if (reg_addr_i[7:4] == NCR_OFS[7:4])
        ncr_q[reg_addr_i[3:2]] <= reg_wdata_i[AW-1:OFS_W];
    end
  end

  always_comb
  begin
    rd_d = '0;
    if (reg_addr_i == CFG_OFS)
      rd_d = cfg_q;
    else if (reg_addr_i == CMD_OFS)
      rd_d[CMD_RDY] = ready_q; // [R6] [R19]
    else if (reg_addr_i[7:4] == NCR_OFS[7:4])
      rd_d[AW-1:OFS_W] = ncr_q[reg_addr_i[3:2]];
    else if (reg_addr_i[7:4] == DMON_OFS[7:4])
      rd_d = mon_cnt[B_D][reg_addr_i[3:2]];
    else if (reg_addr_i[7:4] == IMON_OFS[7:4])
      rd_d = mon_cnt[B_I][reg_addr_i[3:2]];
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_re_i ? rd_d : '0;
  end

  // invalidation requests and main state
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      en_prev_q    <= 1'b0;
      busy_prev_q  <= 1'b0;
      flush_pend_q <= 1'b0;
      ready_q      <= 1'b0;
    end
    else
    begin
      en_prev_q   <= cfg_q[CFG_EN];
      busy_prev_q <= flash_busy_i;
      // a new event in the start cycle still leaves one flush pending
      flush_pend_q <= flush_ev ||
                      (flush_pend_q && st_q != FCC_IDLE); // [R5]
      ready_q <= cfg_q[CFG_EN] && !flush_ev && !flush_pend_q &&
                 st_q != FCC_FLUSH; // [R19]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q    <= FCC_IDLE;
      fcnt_q  <= '0;
      fbus_q  <= 1'b0;
      fwr_q   <= 1'b0;
      fway_q  <= 1'b0;
      faddr_q <= '0;
    end
    else
    begin
      case (st_q)
        FCC_IDLE:
        begin
          if (flush_pend_q)
          begin
            st_q   <= FCC_FLUSH; // [R1]
            fcnt_q <= '0;
          end
          else if (fill_go)
          begin
            st_q    <= FCC_FILL;
            fbus_q  <= fill_bus;
            fwr_q   <= lk_go;
            faddr_q <= lk_go ? la : addr[nc_bus];
            // fill an empty way first, else the policy victim
            fway_q  <= !sif.rd_vld[0] ? 1'b0 :
                       !sif.rd_vld[1] ? 1'b1 : sif.rd_vic;
          end
        end
        FCC_FLUSH:
        begin
          fcnt_q <= fcnt_q + SW'(1);
          if (fcnt_q == SW'(SETS - 1))
            st_q <= FCC_IDLE;
        end
        FCC_FILL:
          if (fill_done)
            st_q <= FCC_IDLE;
        default:
          st_q <= FCC_IDLE;
      endcase
    end
  end

  assign sif.clr_en  = st_q == FCC_FLUSH; // [R1]
  assign sif.clr_set = fcnt_q;
  assign sif.wr_en   = fill_done && fwr_q;
  assign sif.wr_set  = set_of(faddr_q);
  assign sif.wr_way  = fway_q;
  assign sif.wr_tag  = tag_of(faddr_q);
  assign sif.wr_data = fill_data_i;
  // lrr only moves on refill; lru also moves on every hit
  assign sif.vic_we  = sif.wr_en || (lk_hit && cfg_q[CFG_LRU]); // [R21]
  assign sif.vic_set = sif.wr_en ? set_of(faddr_q) : set_of(la);
  assign sif.vic_val = sif.wr_en ? !fway_q : !hit_way;

  // fill path: cache misses first, then info, register, self-test agents
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      own_q       <= 1'b0;
      fill_req_o  <= 1'b0;
      fill_addr_o <= '0;
      agent_gnt_o <= '0;
    end
    else
    begin
      if (fill_done)
      begin
        own_q      <= 1'b0;
        fill_req_o <= 1'b0;
      end
      else if (cache_wants && path_free)
      begin
        own_q       <= 1'b1; // [R10]
        fill_req_o  <= 1'b1; // [R9]
        fill_addr_o <= line_of(faddr_q);
      end
      if (agent_gnt_o != '0)
        agent_gnt_o <= agent_gnt_o & agent_req_i;
      else if (path_free && !cache_wants)
        agent_gnt_o <= agent_req_i & (~agent_req_i + NAG'(1)); // [R10]
    end
  end

  // answers and line buffers
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ibus_ack_o   <= 1'b0;
      dbus_ack_o   <= 1'b0;
      ibus_rdata_o <= '0;
      dbus_rdata_o <= '0;
      rr_q         <= 1'b0;
      lb_v_q       <= '0;
      for (int b = 0; b < 2; b++)
      begin
        lb_line_q[b] <= '0;
        lb_data_q[b] <= '0;
      end
    end
    else
    begin
      if (&need_lk)
        rr_q <= !lk_bus;
      ibus_ack_o <= lbhit[0] || (lk_hit && !lk_bus) ||
                    (fill_done && !fbus_q); // [R9]
      dbus_ack_o <= lbhit[1] || (lk_hit && lk_bus) ||
                    (fill_done && fbus_q);
      if (lbhit[0])
        ibus_rdata_o <= word_of(lb_data_q[0], addr[0]);
      else if (lk_hit && !lk_bus)
        ibus_rdata_o <= word_of(sif.rd_data[hit_way], la);
      else if (fill_done && !fbus_q)
        ibus_rdata_o <= word_of(fill_data_i, faddr_q);
      if (lbhit[1])
        dbus_rdata_o <= word_of(lb_data_q[1], addr[1]);
      else if (lk_hit && lk_bus)
        dbus_rdata_o <= word_of(sif.rd_data[hit_way], la);
      else if (fill_done && fbus_q)
        dbus_rdata_o <= word_of(fill_data_i, faddr_q);
      if (st_q == FCC_FLUSH)
        lb_v_q <= '0; // [R5]
      else if (lk_hit)
      begin
        lb_v_q[lk_bus]    <= 1'b1;
        lb_line_q[lk_bus] <= line_of(la);
        lb_data_q[lk_bus] <= sif.rd_data[hit_way];
      end
      else if (fill_done)
      begin
        lb_v_q[fbus_q]    <= 1'b1;
        lb_line_q[fbus_q] <= line_of(faddr_q);
        lb_data_q[fbus_q] <= fill_data_i;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence flush_start_s;
    st_q == FCC_FLUSH && fcnt_q == '0;
  endsequence
  sequence flush_end_s;
    st_q == FCC_FLUSH ##1 st_q != FCC_FLUSH;
  endsequence

  flush_length_a: assert property ( // [R1]
    flush_start_s |-> ##255 flush_end_s)
    else $error("flush did not cover every set");
  ready_flush_a: assert property ( // [R19]
    st_q == FCC_FLUSH |=> !ready_q)
    else $error("ready shown during invalidation");
  lookup_ready_a: assert property ( // [R2]
    lk_go |-> ready_q && cfg_q[CFG_EN])
    else $error("lookup before startup done");
  nc_bypass_a: assert property ( // [R4]
    lk_go |-> !is_nc(la, cfg_q, ncr_q[0], ncr_q[1], ncr_q[2], ncr_q[3]))
    else $error("non-cacheable fetch looked up");
  disable_inval_a: assert property ( // [R5]
    cfg_q[CFG_EN] != en_prev_q |=> ##[0:2] st_q == FCC_FLUSH ||
                                   flush_pend_q)
    else $error("enable change did not invalidate");
  cmd_inval_a: assert property ( // [R20]
    inv_cmd |=> flush_pend_q)
    else $error("invalidate command lost");
  busy_stall_a: assert property ( // [R11]
    flash_busy_i && !fill_done |=> !ibus_ack_o && !dbus_ack_o)
    else $error("fetch served during flash operation");
  hit_answer_a: assert property ( // [R9]
    lk_hit && !lk_bus |=> ibus_ack_o)
    else $error("hit not answered next cycle");
  miss_fill_a: assert property ( // [R9]
    st_q == FCC_FILL && path_free && !flash_busy_i |=> fill_req_o)
    else $error("miss not sent to flash");
  one_lookup_a: assert property ( // [R17]
    &need_lk |=> ##[0:3] ev[!$past(lk_bus)][MON_LK] || !pend[0])
    else $error("losing bus not looked up");
endmodule : fcc_ctrl

//--- design/fcc_mon.sv
`timescale 1ns/1ps
module fcc_mon
  import fcc_pkg::*;
(
  input  wire logic                                clock_i,
  input  wire logic                                resetn_i,
  input  wire logic [1:0][fcc_pkg::NMON-1:0]       ev_i,
  input  wire logic                                en_i,
  input  wire logic                                clr_i,
  output logic [1:0][fcc_pkg::NMON-1:0][fcc_pkg::DW-1:0] cnt_o
);
  logic frozen;

  // freeze well before wrap so software still reads sane ratios
  assign frozen = (cnt_o[B_I][MON_ACC] >= MON_FREEZE) ||
                  (cnt_o[B_D][MON_ACC] >= MON_FREEZE); // [R14]

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_o <= '0;
    else if (clr_i)
      cnt_o <= '0; // [R15]
    else if (en_i && !frozen) // [R18]
    begin
      for (int b = 0; b < 2; b++)
        for (int k = 0; k < NMON; k++)
          if (ev_i[b][k])
            cnt_o[b][k] <= cnt_o[b][k] + DW'(1); // [R22]
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sum_holds_a: assert property ( // [R13]
    cnt_o[B_I][MON_ACC] == cnt_o[B_I][MON_LK] + cnt_o[B_I][MON_LN] &&
    cnt_o[B_D][MON_ACC] == cnt_o[B_D][MON_LK] + cnt_o[B_D][MON_LN])
    else $error("access count differs from lookups plus lines");
  freeze_hold_a: assert property ( // [R14]
    frozen && !clr_i |=> $stable(cnt_o))
    else $error("counters moved while frozen");
  stat_clear_a: assert property ( // [R15]
    clr_i |=> cnt_o == '0)
    else $error("counters not cleared");
  mon_off_a: assert property ( // [R18]
    !en_i && !clr_i |=> $stable(cnt_o))
    else $error("counters moved while monitor off");
endmodule : fcc_mon

//--- design/fcc_pkg.sv
package fcc_pkg;
  localparam int AW    = 20;
  localparam int DW    = 32;
  localparam int LW    = 128;
  localparam int OFS_W = 4;
  localparam int SW    = 8;
  localparam int SETS  = 256;
  localparam int TW    = AW - SW - OFS_W;
  localparam int LNW   = AW - OFS_W;
  localparam int NAG   = 3;
  localparam int NMON  = 4;

  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] CMD_OFS  = 8'h08;
  localparam logic [7:0] NCR_OFS  = 8'h10;
  localparam logic [7:0] DMON_OFS = 8'h40;
  localparam logic [7:0] IMON_OFS = 8'h50;

  localparam int CFG_EN  = 0;
  localparam int CFG_LRU = 1;
  localparam int CFG_NC0 = 2;
  localparam int CFG_NC1 = 3;
  localparam int CFG_IC  = 8;
  localparam int CFG_DC  = 9;
  localparam int CFG_MON = 24;
  localparam logic [DW-1:0] CFG_RST   = 32'h0016_6c50;
  localparam logic [DW-1:0] CFG_WMASK = 32'h011f_ffff;

  localparam int CMD_INV = 0;
  localparam int CMD_CLR = 1;
  localparam int CMD_RDY = 2;

  localparam int MON_ACC = 0;
  localparam int MON_LK  = 1;
  localparam int MON_HIT = 2;
  localparam int MON_LN  = 3;
  localparam logic [DW-1:0] MON_FREEZE = 32'hffff_0000;

  localparam int B_I = 0;
  localparam int B_D = 1;

  typedef enum logic [1:0] {FCC_IDLE, FCC_FLUSH, FCC_FILL} fcc_state_t;

  function automatic logic [LNW-1:0] line_of(logic [AW-1:0] a);
    return a[AW-1:OFS_W];
  endfunction : line_of

  function automatic logic [SW-1:0] set_of(logic [AW-1:0] a);
    return a[SW+OFS_W-1:OFS_W];
  endfunction : set_of

  function automatic logic [TW-1:0] tag_of(logic [AW-1:0] a);
    return a[AW-1:SW+OFS_W];
  endfunction : tag_of

  function automatic logic [DW-1:0] word_of(logic [LW-1:0] l,
                                            logic [AW-1:0] a);
    return l[a[OFS_W-1:2]*DW +: DW];
  endfunction : word_of
endpackage : fcc_pkg

//--- design/fcc_store.sv
`timescale 1ns/1ps
module fcc_store
  import fcc_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  resetn_i,
  fcc_store_if.store s
);
  // two ways of 256 sets of 128-bit lines: 512 entries, 8 KB
  logic [LW-1:0]   data_mem [2][SETS]; // [R8]
  logic [TW-1:0]   tag_mem  [2][SETS];
  logic [SETS-1:0] vld_q    [2];
  logic [SETS-1:0] vic_q;

  // data and tags need no reset, the valid bits guard them
  always_ff @(posedge clock_i)
  begin
    if (s.wr_en)
    begin
      data_mem[s.wr_way][s.wr_set] <= s.wr_data;
      tag_mem[s.wr_way][s.wr_set]  <= s.wr_tag;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      vld_q[0] <= '0;
      vld_q[1] <= '0;
    end
    else if (s.clr_en)
    begin
      vld_q[0][s.clr_set] <= 1'b0; // [R1]
      vld_q[1][s.clr_set] <= 1'b0;
    end
    else if (s.wr_en)
      vld_q[s.wr_way][s.wr_set] <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      vic_q <= '0;
    else if (s.vic_we)
      vic_q[s.vic_set] <= s.vic_val;
  end

  always_comb
  begin
    for (int w = 0; w < 2; w++)
    begin
      s.rd_tag[w]  = tag_mem[w][s.rd_set];
      s.rd_vld[w]  = vld_q[w][s.rd_set];
      s.rd_data[w] = data_mem[w][s.rd_set];
    end
    s.rd_vic = vic_q[s.rd_set];
  end
endmodule : fcc_store

//--- design/fcc_store_if.sv
`timescale 1ns/1ps
interface fcc_store_if;
  import fcc_pkg::*;
  logic [SW-1:0]         rd_set;
  logic [1:0][TW-1:0]    rd_tag;
  logic [1:0]            rd_vld;
  logic [1:0][LW-1:0]    rd_data;
  logic                  rd_vic;
  logic                  wr_en;
  logic [SW-1:0]         wr_set;
  logic                  wr_way;
  logic [TW-1:0]         wr_tag;
  logic [LW-1:0]         wr_data;
  logic                  vic_we;
  logic [SW-1:0]         vic_set;
  logic                  vic_val;
  logic                  clr_en;
  logic [SW-1:0]         clr_set;
  modport ctrl (output rd_set, wr_en, wr_set, wr_way, wr_tag, wr_data,
                output vic_we, vic_set, vic_val, clr_en, clr_set,
                input rd_tag, rd_vld, rd_data, rd_vic);
  modport store (input rd_set, wr_en, wr_set, wr_way, wr_tag, wr_data,
                 input vic_we, vic_set, vic_val, clr_en, clr_set,
                 output rd_tag, rd_vld, rd_data, rd_vic);
endinterface : fcc_store_if

//--- tb/fcc_flash_model.sv
`timescale 1ns/1ps
module fcc_flash_model
(
  input  wire logic                     clock_i,
  input  wire logic                     req_i,
  input  wire logic [fcc_pkg::LNW-1:0]  addr_i,
  input  wire logic [3:0]               gen_i,
  output logic                          ack_o,
  output logic [fcc_pkg::LW-1:0]        data_o
);
  import fcc_pkg::*;
  integer        seed = 95954;
  integer        wt;
  logic [LW-1:0] last;
  initial
  begin
    ack_o = 1'b0;
    last = '1;
    data_o = last;
    forever
    begin
      @(posedge clock_i);
      if (req_i === 1'b1)
      begin
        // prompt or slow fill, 1 to 4 cycles
        wt = 1 + ($unsigned($random(seed)) % 4);
        repeat (wt) @(posedge clock_i);
        for (int k = 0; k < 4; k++)
          last[k*DW +: DW] = {gen_i, addr_i, 8'h00, 4'(k)};
        ack_o <= 1'b1;
        data_o <= last;
        @(posedge clock_i);
        ack_o <= 1'b0;
        // released data lines must not look valid
        data_o <= ~last;
      end
    end
  end
endmodule : fcc_flash_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fcc_pkg::*;
  localparam logic [DW-1:0] ON = CFG_RST | 32'h0100_0301;
  logic           clock_i = 1'b0;
  logic           resetn_i = 1'b0;
  logic [7:0]     ra = 8'h00;
  logic [DW-1:0]  wd = '0;
  logic           we = 1'b0;
  logic           re = 1'b0;
  logic [DW-1:0]  rdat;
  logic [1:0]     req = 2'b00;
  logic [AW-1:0]  fa [2];
  logic [1:0]     ack;
  logic [DW-1:0]  fd [2];
  logic           busy = 1'b0;
  logic           freq;
  logic           fack;
  logic [LNW-1:0] fad;
  logic [LW-1:0]  fdat;
  logic [NAG-1:0] areq = '0;
  logic [NAG-1:0] gnt;
  logic [3:0]     gen = 4'h0;
  logic [DW-1:0]  v;
  logic [AW-1:0]  a;
  logic           mon = 1'b0;
  integer         seed = 95954;
  integer         num_errors = 0;
  integer         cmp_count = 0;
  integer         nfill = 0;
  integer         nf;
  integer         lat;
  integer         nrd [2];

  initial forever #2 clock_i = ~clock_i;
  always @(posedge clock_i) if (fack === 1'b1) nfill++;

  fcc_ctrl fcc_ctrl_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdat), .ibus_req_i(req[0]), .ibus_addr_i(fa[0]),
    .ibus_ack_o(ack[0]), .ibus_rdata_o(fd[0]), .dbus_req_i(req[1]),
    .dbus_addr_i(fa[1]), .dbus_ack_o(ack[1]), .dbus_rdata_o(fd[1]),
    .flash_busy_i(busy), .fill_req_o(freq), .fill_addr_o(fad),
    .fill_ack_i(fack), .fill_data_i(fdat), .agent_req_i(areq),
    .agent_gnt_o(gnt));
  fcc_flash_model fcc_flash_model_inst (.clock_i(clock_i), .req_i(freq),
    .addr_i(fad), .gen_i(gen), .ack_o(fack), .data_o(fdat));

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [DW-1:0] d);
    @(posedge clock_i);
    ra <= ad;
    wd <= d;
    we <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(posedge clock_i);
    ra <= ad;
    re <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    #1 v = rdat;
  endtask : rd

  // request held until the edge that samples the ack
  task automatic fetch(input int b, input logic [AW-1:0] ad);
    @(posedge clock_i);
    req[b] <= 1'b1;
    fa[b] <= ad;
    lat = 0;
    do
    begin
      @(posedge clock_i);
      #1 lat++;
    end while (ack[b] !== 1'b1 && lat < 900);
    chk("fetch ack", 1, ack[b]);
    chk("fetch data", {gen, ad[19:4], 10'h000, ad[3:2]}, fd[b]);
    if (mon)
      nrd[b]++;
    @(posedge clock_i);
    req[b] <= 1'b0;
  endtask : fetch

  task automatic mchk(input int b);
    logic [DW-1:0] t;
    logic [DW-1:0] l;
    logic [7:0]    o;
    o = (b == B_I) ? IMON_OFS : DMON_OFS;
    rd(o);
    t = v;
    chk("read total", DW'(nrd[b]), t);
    rd(o + 8'h04);
    l = v;
    rd(o + 8'h08);
    chk("hits within lookups", 1, v <= l);
    rd(o + 8'h0c);
    chk("lookup plus line", t, l + v);
  endtask : mchk

  initial
  begin
    #40000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    fa[0] = '0;
    fa[1] = '0;
    nrd[0] = 0;
    nrd[1] = 0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(CFG_OFS);
    chk("cfg reset", CFG_RST, v);
    rd(CMD_OFS);
    chk("ready at reset", 0, v);
    rd(8'h24);
    chk("unmapped read", 0, v);
    wr(CFG_OFS, ON);
    rd(CMD_OFS);
    chk("ready in flush", 0, v);
    repeat (300) @(posedge clock_i);
    rd(CMD_OFS);
    chk("ready after flush", 32'h4, v);
    rd(CFG_OFS);
    chk("cfg readback", ON & CFG_WMASK, v);
    $display("test enable done");
    mon = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      a = AW'($random(seed)) & 20'h0007c;
      fetch(i % 2, a);
    end
    fetch(0, 20'h00104);
    fetch(1, 20'h00104);
    chk("hit latency", 1, lat);
    // both buses miss together: one waits for the tag port
    fork
      fetch(0, 20'h00204);
      fetch(1, 20'h00304);
    join
    wr(CFG_OFS, ON & ~32'h0100_0000);
    mon = 1'b0;
    mchk(B_I);
    mchk(B_D);
    fetch(0, 20'h00108);
    mchk(B_I);
    wr(CMD_OFS, 32'h2);
    nrd[0] = 0;
    nrd[1] = 0;
    mchk(B_I);
    mchk(B_D);
    $display("test monitors done");
    wr(CFG_OFS, ON & ~32'h0100_0100);
    nf = nfill;
    fetch(0, 20'h00208);
    fetch(0, 20'h00104);
    fetch(1, 20'h00104);
    chk("fills with instr caching off", 2, nfill - nf);
    gen <= gen + 4'h1;
    busy <= 1'b1;
    fork
      fetch(1, 20'h00104);
      begin
        repeat (40) @(posedge clock_i);
        busy <= 1'b0;
      end
    join
    chk("held while flash busy", 1, lat > 39);
    gen <= gen + 4'h1;
    wr(CMD_OFS, 32'h1);
    rd(CMD_OFS);
    chk("status while invalidating", 0, v);
    repeat (300) @(posedge clock_i);
    fetch(1, 20'h00104);
    $display("test invalidation done");
    gen <= gen + 4'h1;
    wr(CFG_OFS, 32'h0);
    wr(NCR_OFS, 32'h0000_0300);
    wr(NCR_OFS + 8'h04, 32'h0000_0300);
    wr(CFG_OFS, (ON & ~32'h0100_0000) | 32'h6);
    repeat (300) @(posedge clock_i);
    nf = nfill;
    fetch(1, 20'h00104);
    fetch(1, 20'h00300);
    fetch(1, 20'h00404);
    fetch(1, 20'h00300);
    fetch(1, 20'h00404);
    chk("fills with region bypass", 4, nfill - nf);
    areq <= 3'b101;
    repeat (3) @(posedge clock_i);
    areq <= 3'b100;
    #1 chk("grant lowest agent", 32'h1, gnt);
    repeat (4) @(posedge clock_i);
    areq <= 3'b000;
    #1 chk("grant next agent", 32'h4, gnt);
    $display("test regions and agents done");
    end_sim();
  end
endmodule : testbench
